// *** verilog/rx_filter_pkg.sv ***
package rx_filter_pkg;
  localparam int NUM_CH = 6;
  localparam int NUM_CH_3G = 3;
  // register byte offsets
  localparam logic [7:0] OFS_SELECT = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_CFG = 8'h08;
  localparam logic [7:0] OFS_DST_IP = 8'h0c;
  localparam logic [7:0] OFS_SRC_IP = 8'h10;
  localparam logic [7:0] OFS_PORTS = 8'h14;
  localparam logic [7:0] OFS_SSRC = 8'h18;
  localparam logic [7:0] OFS_VLAN = 8'h1c;
  localparam logic [7:0] OFS_CH_COUNT = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_GEN_RX = 8'h28;
  localparam logic [7:0] OFS_GEN_DROP = 8'h2c;
  localparam logic [7:0] OFS_CORE = 8'h30;
  localparam logic [7:0] OFS_TS_OFFSET = 8'h34;
  // command bits
  localparam int CMD_CH_INIT = 0;
  localparam int CMD_CH_ENABLE = 1;
  localparam int CMD_CH_STAT_CLR = 2;
  localparam int CMD_CORE_RESET = 3;
  localparam int CMD_CORE_INIT = 4;
  localparam int CMD_GEN_STAT_CLR = 5;
  // cfg fields
  localparam int CFG_VLAN_MATCH = 0;
  localparam int CFG_TS_BYPASS = 1;
  localparam int CFG_SEL_POS = 2;
  // select bits: ssrc, dst udp, src udp, dst ip, src ip, vlan
  localparam int SEL_SSRC = 0;
  localparam int SEL_DPORT = 1;
  localparam int SEL_SPORT = 2;
  localparam int SEL_DIP = 3;
  localparam int SEL_SIP = 4;
  localparam int SEL_VLAN = 5;
  // default channel values
  localparam logic [5:0] SEL_RESET = 6'h06;
  localparam logic [31:0] DST_IP_RESET = 32'hc0a8050a;
  localparam logic [31:0] SRC_IP_RESET = 32'hc0a8050b;
  localparam logic [15:0] PORT_RESET = 16'h2710;
  localparam logic [31:0] SSRC_RESET = 32'h12345600;
  localparam logic [11:0] VLAN_RESET = 12'h000;

  typedef struct packed {
    logic [31:0] ssrc;
    logic [15:0] dst_port;
    logic [15:0] src_port;
    logic [31:0] dst_ip;
    logic [31:0] src_ip;
    logic [11:0] vlan;
  } hdr_t;

  typedef struct packed {
    logic enable;
    logic vlan_match;
    logic ts_bypass;
    logic [5:0] sel;
    hdr_t match;
  } chan_cfg_t;

  typedef struct packed {
    logic vid_locked;
    logic frame_synced;
    logic hitless_prot;
    logic fec_locked;
  } chan_stat_t;
endpackage

// *** verilog/rx_channel_filter.sv ***
// Implementation choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
// Overview of operation
// RL1 - six channels, chosen by index one to six
// RL2 - enable toggles per command; disabled drops stream
// RL3 - vlan match adds vlan tag to compare
// RL4 - timestamp bypass selects timestamp use
// RL5 - include/exclude select for six header fields
// RL6 - programmable destination ip per channel
// RL7 - programmable source ip per channel
// RL8 - programmable destination udp port per channel
// RL9 - programmable source udp port per channel
// RL10 - programmable rtp ssrc per channel
// RL11 - per-channel packet counters, per-channel clear
// RL12 - general counters with their own clear
// RL13 - core reset returns everything to reset
// RL14 - core init defaults all; channel init one
// RL15 - software initializes after every core reset
// RL16 - mac fault inhibit on/off setting
// RL17 - per-channel lock, sync, hitless, fec status
// RL18 - matched packets forwarded toward sdi depacketizer
// RL19 - capacity three channels when any 3g stream; here any_3g follows only the last valid packet's pkt_3g
// RL20 - match needs enable and all selected fields equal
// RL21 - unmatched packets dropped, counters untouched; gen_rx and gen_drop still count them
module rx_channel_filter (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // parsed packet headers from the mac side
  input wire logic pkt_valid,
  input wire rx_filter_pkg::hdr_t pkt_hdr,
  input wire logic pkt_3g,
  input wire logic mac_fault,
  // per-channel status from the depacketizers
  input wire rx_filter_pkg::chan_stat_t [5:0] ch_status,
  input wire logic [31:0] timestamp_offset_report,
  // delivery
  output logic [5:0] pkt_deliver,
  output logic [5:0] ch_use_ts,
  output logic [5:0] ch_active,
  output logic mac_fault_act,
  output logic core_reset_out
);
  import rx_filter_pkg::*;

  chan_cfg_t cfg [NUM_CH];
  logic [31:0] ch_count [NUM_CH];
  logic [31:0] gen_rx;
  logic [31:0] gen_drop;
  logic [2:0] sel_idx;
  logic fault_inhibit;
  logic any_3g;
  logic rd_pend;

  wire wr_ok = avs_write && avs_byteenable == 4'hf;
  wire wr_cmd = wr_ok && avs_address == OFS_CMD;
  wire wr_core = wr_ok && avs_address == OFS_CORE;
  wire do_core_reset = wr_cmd && avs_writedata[CMD_CORE_RESET]; //RL13
  wire do_core_init = wr_cmd && avs_writedata[CMD_CORE_INIT]; //RL14
  wire do_gen_clr = wr_cmd && avs_writedata[CMD_GEN_STAT_CLR]; //RL12
  wire idx_ok = sel_idx >= 3'd1 && sel_idx <= 3'd6; //RL1
  wire [2:0] cur = idx_ok ? sel_idx - 3'd1 : 3'd0;
  wire [2:0] cap = any_3g ? 3'(NUM_CH_3G) : 3'(NUM_CH); //RL19

  function automatic chan_cfg_t cfg_default();
    chan_cfg_t c;
    c.enable = 1'b0;
    c.vlan_match = 1'b0;
    c.ts_bypass = 1'b0;
    c.sel = SEL_RESET;
    c.match.ssrc = SSRC_RESET;
    c.match.dst_port = PORT_RESET;
    c.match.src_port = PORT_RESET;
    c.match.dst_ip = DST_IP_RESET;
    c.match.src_ip = SRC_IP_RESET;
    c.match.vlan = VLAN_RESET;
    return c;
  endfunction

  // filter compare: each selected field must equal
  function automatic logic hdr_match(chan_cfg_t c, hdr_t h);
    logic m;
    m = c.enable; //RL20
    if (c.sel[SEL_SSRC] && h.ssrc != c.match.ssrc) m = 1'b0; //RL10
    if (c.sel[SEL_DPORT] && h.dst_port != c.match.dst_port) m = 1'b0; //RL8
    if (c.sel[SEL_SPORT] && h.src_port != c.match.src_port) m = 1'b0; //RL9
    if (c.sel[SEL_DIP] && h.dst_ip != c.match.dst_ip) m = 1'b0; //RL6
    if (c.sel[SEL_SIP] && h.src_ip != c.match.src_ip) m = 1'b0; //RL7
    if ((c.sel[SEL_VLAN] || c.vlan_match) && h.vlan != c.match.vlan) m = 1'b0; //RL3 RL5
    return m;
  endfunction

  logic [5:0] hit;
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : gch
      wire sel_me = idx_ok && cur == 3'(g);
      wire in_cap = 3'(g) < cap;
      assign hit[g] = pkt_valid && in_cap && hdr_match(cfg[g], pkt_hdr); //RL20
      assign ch_use_ts[g] = ~cfg[g].ts_bypass; //RL4
      assign ch_active[g] = cfg[g].enable && in_cap; //RL2
      always_ff @(posedge clk_sys) begin
        if (rst || do_core_reset || do_core_init) begin
          cfg[g] <= cfg_default(); //RL14
        end else if (sel_me && wr_cmd && avs_writedata[CMD_CH_INIT]) begin
          cfg[g] <= cfg_default(); //RL14
        end else if (sel_me && wr_ok) begin
          if (avs_address == OFS_CMD && avs_writedata[CMD_CH_ENABLE])
            cfg[g].enable <= ~cfg[g].enable; //RL2
          if (avs_address == OFS_CFG) begin
            cfg[g].vlan_match <= avs_writedata[CFG_VLAN_MATCH]; //RL3
            cfg[g].ts_bypass <= avs_writedata[CFG_TS_BYPASS]; //RL4
            cfg[g].sel <= avs_writedata[CFG_SEL_POS +: 6]; //RL5
          end
          if (avs_address == OFS_DST_IP) cfg[g].match.dst_ip <= avs_writedata; //RL6
          if (avs_address == OFS_SRC_IP) cfg[g].match.src_ip <= avs_writedata; //RL7
          if (avs_address == OFS_PORTS) begin
            cfg[g].match.dst_port <= avs_writedata[31:16]; //RL8
            cfg[g].match.src_port <= avs_writedata[15:0]; //RL9
          end
          if (avs_address == OFS_SSRC) cfg[g].match.ssrc <= avs_writedata; //RL10
          if (avs_address == OFS_VLAN) cfg[g].match.vlan <= avs_writedata[11:0];
        end
      end
      // counter: clear and increment in the same cycle leave a count of one
      always_ff @(posedge clk_sys) begin
        if (rst || do_core_reset) begin
          ch_count[g] <= 32'h0;
        end else if (hit[g]) begin
          ch_count[g] <= (sel_me && wr_cmd && avs_writedata[CMD_CH_STAT_CLR]) ?
                         32'h1 : ch_count[g] + 32'h1; //RL11
        end else if (sel_me && wr_cmd && avs_writedata[CMD_CH_STAT_CLR]) begin
          ch_count[g] <= 32'h0; //RL11
        end
      end
    end
  endgenerate

  wire pkt_drop = pkt_valid && hit == 6'h0; //RL21

  always_ff @(posedge clk_sys) begin
    if (rst || do_core_reset) begin
      gen_rx <= 32'h0;
      gen_drop <= 32'h0;
    end else begin
      if (pkt_valid) gen_rx <= do_gen_clr ? 32'h1 : gen_rx + 32'h1; //RL12
      else if (do_gen_clr) gen_rx <= 32'h0;
      if (pkt_drop) gen_drop <= do_gen_clr ? 32'h1 : gen_drop + 32'h1; //RL21
      else if (do_gen_clr) gen_drop <= 32'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || do_core_reset) begin
      sel_idx <= 3'h1;
      fault_inhibit <= 1'b0;
      any_3g <= 1'b0;
      pkt_deliver <= 6'h0;
      core_reset_out <= 1'b0;
    end else begin
      if (wr_ok && avs_address == OFS_SELECT) sel_idx <= avs_writedata[2:0]; //RL1
      if (wr_core) fault_inhibit <= avs_writedata[0]; //RL16
      if (pkt_valid) any_3g <= pkt_3g; //RL19
      pkt_deliver <= hit; //RL18
      core_reset_out <= 1'b0;
    end
    if (do_core_reset) core_reset_out <= 1'b1; //RL13
  end

  assign mac_fault_act = mac_fault && !fault_inhibit; //RL16

  // read answers one cycle after the request
  wire chan_stat_t st = ch_status[cur];
  wire [31:0] rd_mux =
    avs_address == OFS_SELECT ? {29'h0, sel_idx} :
    avs_address == OFS_CFG ? {23'h0, cfg[cur].enable, cfg[cur].sel,
                              cfg[cur].ts_bypass, cfg[cur].vlan_match} :
    avs_address == OFS_DST_IP ? cfg[cur].match.dst_ip :
    avs_address == OFS_SRC_IP ? cfg[cur].match.src_ip :
    avs_address == OFS_PORTS ? {cfg[cur].match.dst_port, cfg[cur].match.src_port} :
    avs_address == OFS_SSRC ? cfg[cur].match.ssrc :
    avs_address == OFS_VLAN ? {20'h0, cfg[cur].match.vlan} :
    avs_address == OFS_CH_COUNT ? ch_count[cur] : //RL11
    avs_address == OFS_STATUS ? {27'h0, any_3g, st.fec_locked, st.hitless_prot,
                                 st.frame_synced, st.vid_locked} : //RL17
    avs_address == OFS_GEN_RX ? gen_rx :
    avs_address == OFS_GEN_DROP ? gen_drop :
    avs_address == OFS_CORE ? {31'h0, fault_inhibit} :
    avs_address == OFS_TS_OFFSET ? timestamp_offset_report :
    32'h0;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_pend <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      rd_pend <= avs_read && !rd_pend;
      if (avs_read && !rd_pend) avs_readdata <= rd_mux;
    end
  end

  assign avs_waitrequest = avs_read && !rd_pend;

  AST_DISABLED_NO_HIT: assert property (@(posedge clk_sys) disable iff (rst)
    !cfg[0].enable |-> !hit[0]) else $error("disabled channel hit"); //RL2
  AST_DROP_NO_COUNT: assert property (@(posedge clk_sys) disable iff (rst)
    (pkt_drop && !(wr_cmd)) |=> ch_count[0] == $past(ch_count[0]))
    else $error("drop changed count"); //RL21
  AST_COUNT_INC: assert property (@(posedge clk_sys) disable iff (rst)
    (hit[0] && !wr_cmd) |=> ch_count[0] == $past(ch_count[0]) + 32'h1)
    else $error("count not incremented"); //RL11
  AST_DELIVER: assert property (@(posedge clk_sys) disable iff (rst)
    (hit != 6'h0 && !do_core_reset) |=> pkt_deliver == $past(hit))
    else $error("deliver mismatch"); //RL18
  AST_CAP3: assert property (@(posedge clk_sys) disable iff (rst)
    any_3g |-> hit[5:3] == 3'h0) else $error("3g capacity exceeded"); //RL19
  AST_CORE_RST: assert property (@(posedge clk_sys) disable iff (rst)
    do_core_reset |=> gen_rx == 32'h0 && core_reset_out) else $error("core reset"); //RL13
  AST_INIT: assert property (@(posedge clk_sys) disable iff (rst)
    do_core_init |=> !cfg[0].enable && cfg[0].sel == SEL_RESET)
    else $error("init not default"); //RL14
  AST_FAULT: assert property (@(posedge clk_sys) disable iff (rst)
    fault_inhibit |-> !mac_fault_act) else $error("fault not inhibited"); //RL16
  AST_RD_WAIT: assert property (@(posedge clk_sys) disable iff (rst)
    (avs_read && avs_waitrequest) |=> !avs_waitrequest) else $error("read stalls"); //RL1
  COV_HIT: cover property (@(posedge clk_sys) hit[0]);
  COV_DROP: cover property (@(posedge clk_sys) pkt_drop);
  COV_3G: cover property (@(posedge clk_sys) any_3g && pkt_valid);
  COV_INIT: cover property (@(posedge clk_sys) do_core_init);
endmodule

// *** tb/eth_rx_model.sv ***
`timescale 1ns/10ps
module eth_rx_model (
  // clock
  input wire logic clk_sys,
  // parsed header stream
  output logic pkt_valid,
  output rx_filter_pkg::hdr_t pkt_hdr,
  output logic pkt_3g
);
  import rx_filter_pkg::*;
  initial begin
    pkt_valid = 1'b0;
    pkt_hdr = '0;
    pkt_3g = 1'b0;
  end
  // one header per call, launched just after a rising edge
  task automatic send(input hdr_t h, input logic g);
    pkt_valid <= 1'b1;
    pkt_hdr <= h;
    pkt_3g <= g;
    @(posedge clk_sys);
    pkt_valid <= 1'b0;
    // stale header must not look valid
    pkt_hdr <= ~h;
    pkt_3g <= ~g;
  endtask
endmodule

// *** tb/st2022_rx_channel_filter_bench.sv ***
`timescale 1ns/10ps
module st2022_rx_channel_filter_bench;
  import rx_filter_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic mac_fault = 1'b0;
  logic seen_rst = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] rdat;
  logic [3:0] be = 4'hf;
  chan_stat_t [5:0] ch_status = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, pkt_valid, pkt_3g, mac_fault_act, core_reset_out;
  hdr_t pkt_hdr;
  hdr_t h0;
  logic [5:0] pkt_deliver, ch_use_ts, ch_active;
  int num_errors = 0;
  int n_compared = 0;
  int fpos [5] = '{108, 92, 76, 44, 12};
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (core_reset_out === 1'b1) seen_rst <= 1'b1;
  end
  eth_rx_model u_net (.clk_sys(clk_sys), .pkt_valid(pkt_valid), .pkt_hdr(pkt_hdr),
    .pkt_3g(pkt_3g));
  rx_channel_filter u_dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(be), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pkt_valid(pkt_valid), .pkt_hdr(pkt_hdr), .pkt_3g(pkt_3g), .mac_fault(mac_fault),
    .ch_status(ch_status), .timestamp_offset_report(32'h00005a5a),
    .pkt_deliver(pkt_deliver),
    .ch_use_ts(ch_use_ts), .ch_active(ch_active), .mac_fault_act(mac_fault_act),
    .core_reset_out(core_reset_out));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // request held until waitrequest is low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), rdat, exp);
  endtask
  task automatic pk(input hdr_t h, input logic g, input logic [5:0] exp);
    u_net.send(h, g);
    @(negedge clk_sys);
    chk("deliver", 32'(pkt_deliver), 32'(exp));
    @(posedge clk_sys);
  endtask
  task automatic t_defaults;
    rdc(OFS_CFG, 32'h18);
    rdc(OFS_DST_IP, DST_IP_RESET);
    rdc(OFS_SRC_IP, SRC_IP_RESET);
    rdc(OFS_PORTS, {PORT_RESET, PORT_RESET});
    rdc(OFS_SSRC, SSRC_RESET);
    rdc(8'h3c, 32'h0);
    chk("use_ts", 32'(ch_use_ts), 32'h3f);
    chk("active", 32'(ch_active), 32'h0);
    $display("done defaults");
  endtask
  task automatic t_match;
    wr(OFS_SELECT, 32'h2);
    wr(OFS_CMD, 32'h2);
    wr(OFS_CFG, 32'h7c);
    pk(h0, 1'b0, 6'h02);
    for (int f = 0; f < 5; f++) pk(h0 ^ (hdr_t'(1) << fpos[f]), 1'b0, 6'h00);
    rdc(OFS_CH_COUNT, 32'h1);
    wr(OFS_SELECT, 32'h7);
    wr(OFS_DST_IP, 32'h0);
    wr(OFS_SELECT, 32'h2);
    be <= 4'h3;
    wr(OFS_SSRC, 32'h0);
    be <= 4'hf;
    rdc(OFS_DST_IP, DST_IP_RESET);
    rdc(OFS_SSRC, SSRC_RESET);
    $display("done match");
  endtask
  task automatic t_vlan;
    wr(OFS_VLAN, 32'h5);
    wr(OFS_CFG, 32'h1b);
    pk(h0, 1'b0, 6'h00);
    pk(h0 | hdr_t'(5), 1'b0, 6'h02);
    chk("use_ts", 32'(ch_use_ts), 32'h3d);
    $display("done vlan");
  endtask
  task automatic t_stats;
    rdc(OFS_CH_COUNT, 32'h2);
    wr(OFS_CMD, 32'h4);
    rdc(OFS_CH_COUNT, 32'h0);
    wr(OFS_CMD, 32'h20);
    pk(h0, 1'b0, 6'h00);
    rdc(OFS_GEN_DROP, 32'h1);
    rdc(OFS_GEN_RX, 32'h1);
    wr(OFS_CMD, 32'h2);
    pk(h0 | hdr_t'(5), 1'b0, 6'h00);
    rdc(OFS_CH_COUNT, 32'h0);
    $display("done stats");
  endtask
  task automatic t_status;
    ch_status[1] <= '{1'b1, 1'b1, 1'b0, 1'b1};
    mac_fault <= 1'b1;
    rdc(OFS_STATUS, 32'h0b);
    rdc(OFS_TS_OFFSET, 32'h00005a5a);
    chk("fault", 32'(mac_fault_act), 32'h1);
    wr(OFS_CORE, 32'h1);
    chk("fault", 32'(mac_fault_act), 32'h0);
    $display("done status");
  endtask
  task automatic t_cap;
    wr(OFS_SELECT, 32'h5);
    wr(OFS_CMD, 32'h2);
    chk("active", 32'(ch_active), 32'h10);
    pk(h0 ^ (hdr_t'(1) << 92), 1'b1, 6'h00);
    chk("active", 32'(ch_active), 32'h0);
    rdc(OFS_STATUS, 32'h10);
    $display("done capacity");
  endtask
  task automatic t_core;
    wr(OFS_CFG, 32'h1b);
    wr(OFS_CMD, 32'h1);
    rdc(OFS_CFG, 32'h18);
    wr(OFS_SELECT, 32'h2);
    rdc(OFS_CFG, 32'h1b);
    wr(OFS_CMD, 32'h10);
    rdc(OFS_CFG, 32'h18);
    wr(OFS_CMD, 32'h8);
    repeat (3) @(posedge clk_sys);
    chk("core_reset", 32'(seen_rst), 32'h1);
    rdc(OFS_GEN_RX, 32'h0);
    chk("active", 32'(ch_active), 32'h0);
    wr(OFS_CMD, 32'h10);
    rdc(OFS_CFG, 32'h18);
    $display("done core");
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    h0 = '{SSRC_RESET, PORT_RESET, PORT_RESET, DST_IP_RESET, SRC_IP_RESET, VLAN_RESET};
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_defaults();
    t_match();
    t_vlan();
    t_stats();
    t_status();
    t_cap();
    t_core();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    give_verdict();
  end
endmodule
